// File: pkg/dmae_consts.vh
// Constants of the debug memory access engine: test-port register indexes,
// control/status field positions, bus encodings and the fault message layout.
// Assumes it is included by bare name from design files.
`ifndef DMAE_CONSTS_VH
`define DMAE_CONSTS_VH

// ==========================================================================
// Test-port register indexes
`define DMAE_IDX_CSR        4'h7
`define DMAE_IDX_ADDR       4'h9
`define DMAE_IDX_DATA       4'ha
`define DMAE_IR_RESET       4'h7

// ==========================================================================
// Control/status fields
`define DMAE_F_GO           31
`define DMAE_F_MAP_HI       30
`define DMAE_F_MAP_LO       28
`define DMAE_F_PRIO_HI      27
`define DMAE_F_PRIO_LO      26
`define DMAE_F_DIR          25
`define DMAE_F_SIZE_HI      24
`define DMAE_F_SIZE_LO      22
`define DMAE_F_CNT_HI       21
`define DMAE_F_CNT_LO       8
`define DMAE_F_ERR          1
`define DMAE_F_DV           0
`define DMAE_CSR_RESET      32'h0000_0000

// ==========================================================================
// Transfer widths and bus encodings
`define DMAE_SIZE_8         3'h0
`define DMAE_SIZE_16        3'h1
`define DMAE_SIZE_32        3'h2
`define DMAE_HTRANS_IDLE    2'h0
`define DMAE_HTRANS_NONSEQ  2'h2
`define DMAE_HRESP_ERROR    2'h1

// ==========================================================================
// Fault message
`define DMAE_ERR_CODE       5'h03
`define DMAE_TCODE_ERR      6'h08
`define DMAE_SRC_PROC       4'h0

// ==========================================================================
// Read data buffer
`define DMAE_FIFO_DEPTH     8
`define DMAE_FIFO_AW        3

`endif

// File: design/dmae_top.v
// Debug memory access engine: a test-port register file that drives single
// and block transfers as a system bus master, with a read data buffer.
// Assumes the bus runs on clk; all test-port pins are asynchronous to clk.
`timescale 1ns/1ps
`include "dmae_consts.vh"

// ==========================================================================
// Read data buffer
module dmae_fifo #(
    parameter W  = 32,
    parameter D  = `DMAE_FIFO_DEPTH,
    parameter AW = `DMAE_FIFO_AW
) (
    input  wire         clk,
    input  wire         rstn,
    input  wire         flush,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg  [W-1:0] mem [0:D-1];
    reg  [AW-1:0] wr_ptr;
    reg  [AW-1:0] rd_ptr;
    reg  [AW:0]   fill;
    wire          push = in_valid && in_ready;
    wire          pop  = out_valid && out_ready;

    assign in_ready  = (fill != D[AW:0]);
    assign out_valid = (fill != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];

    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            fill   <= {(AW+1){1'b0}};
        end else if (flush) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            fill   <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                fill <= fill + 1'b1;
            end else if (pop && !push) begin
                fill <= fill - 1'b1;
            end
        end
    end
endmodule // dmae_fifo

// Functional notes
// - Registers at indexes 0x7, 0x9, 0xA.
// - Control write with go set starts access; a write waits for the data register write.
// - Urgency field drives bus priority; 00 lowest.
// - Direction 1 writes, 0 reads.
// - Width field selects 8, 16, 32 bits.
// - Count 0 or 1 single, else block.
// - Write moves data register to address.
// - Single write done: ready, clear data-valid.
// - Each block beat: advance address, decrement, ready.
// - Block write ends: data-valid cleared.
// - Working copies keep programmed address and count.
// - Read fills data register, ready, data-valid set.
// - Block read ends: data-valid set.
// - Data shifts 32 bits, LSB first.
// - Bus error ends access, clears go, sets fault.
// - Bus error issues fault message type 8.
// - Message: code 00011, source, type 001000.
// - Control write mid-block stops after current beat.
// - Access only outside system reset, clocks running.
// - Misaligned addresses are not corrected.
// - Ready holds until Capture-DR; off in reset.
module dmae_top #(
    parameter [3:0] SRC_PROC = `DMAE_SRC_PROC
) (
    input  wire        clk,
    input  wire        rstn,
    input  wire        tclk,
    input  wire        tms,
    input  wire        tdi,
    input  wire        trst_n,
    output reg         tdo,
    output reg         tdo_oe,
    output reg         rdy_n,
    input  wire        sys_rstn,
    input  wire        dbg_enable,
    output reg         hbusreq,
    input  wire        hgrant,
    output reg  [31:0] haddr,
    output reg  [1:0]  htrans,
    output reg         hwrite,
    output reg  [2:0]  hsize,
    output reg  [31:0] hwdata,
    input  wire [31:0] hrdata,
    input  wire        hready,
    input  wire [1:0]  hresp,
    output reg  [1:0]  bus_prio,
    output reg  [14:0] err_msg,
    output reg         err_msg_valid
);
    localparam [3:0] T_EX2DR = 4'h0, T_EX1DR = 4'h1, T_SHDR = 4'h2, T_PAUDR = 4'h3;
    localparam [3:0] T_SELIR = 4'h4, T_UPDR = 4'h5, T_CAPDR = 4'h6, T_SELDR = 4'h7;
    localparam [3:0] T_EX2IR = 4'h8, T_EX1IR = 4'h9, T_SHIR = 4'ha, T_PAUIR = 4'hb;
    localparam [3:0] T_RTI = 4'hc, T_UPIR = 4'hd, T_CAPIR = 4'he, T_TLR = 4'hf;
    localparam [1:0] B_IDLE = 2'h0, B_REQ = 2'h1, B_ADDR = 2'h2, B_DATA = 2'h3;

    // ======================================================================
    // Pin synchronisers
    // All six pins pass two flops; a third tclk stage feeds the edge detector.
    reg  [5:0]  pin_s1;
    reg  [5:0]  pin_s2;
    reg         tclk_s3;
    wire        tclk_rise = pin_s2[0] && !tclk_s3;
    wire        tclk_fall = !pin_s2[0] && tclk_s3;
    wire        tms_s     = pin_s2[1];
    wire        tdi_s     = pin_s2[2];
    wire        trst_s    = pin_s2[3];
    wire        sys_ok    = pin_s2[4] && pin_s2[5];

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1  <= 6'h00;
            pin_s2  <= 6'h00;
            tclk_s3 <= 1'b0;
        end else begin
            pin_s1  <= {dbg_enable, sys_rstn, trst_n, tdi, tms, tclk};
            pin_s2  <= pin_s1;
            tclk_s3 <= pin_s2[0];
        end
    end

    // ======================================================================
    // Test-port controller
    reg  [3:0]  tap;
    reg  [3:0]  next_tap;
    reg  [3:0]  ir;
    reg  [3:0]  ir_shift;
    reg  [31:0] dr_shift;
    reg  [31:0] csr;
    reg  [31:0] addr_reg;
    reg  [31:0] data_reg;

    always @* begin
        case (tap)
            T_TLR:   next_tap = tms_s ? T_TLR   : T_RTI;
            T_RTI:   next_tap = tms_s ? T_SELDR : T_RTI;
            T_SELDR: next_tap = tms_s ? T_SELIR : T_CAPDR;
            T_CAPDR: next_tap = tms_s ? T_EX1DR : T_SHDR;
            T_SHDR:  next_tap = tms_s ? T_EX1DR : T_SHDR;
            T_EX1DR: next_tap = tms_s ? T_UPDR  : T_PAUDR;
            T_PAUDR: next_tap = tms_s ? T_EX2DR : T_PAUDR;
            T_EX2DR: next_tap = tms_s ? T_UPDR  : T_SHDR;
            T_UPDR:  next_tap = tms_s ? T_SELDR : T_RTI;
            T_SELIR: next_tap = tms_s ? T_TLR   : T_CAPIR;
            T_CAPIR: next_tap = tms_s ? T_EX1IR : T_SHIR;
            T_SHIR:  next_tap = tms_s ? T_EX1IR : T_SHIR;
            T_EX1IR: next_tap = tms_s ? T_UPIR  : T_PAUIR;
            T_PAUIR: next_tap = tms_s ? T_EX2IR : T_PAUIR;
            T_EX2IR: next_tap = tms_s ? T_UPIR  : T_SHIR;
            default: next_tap = tms_s ? T_SELDR : T_RTI;
        endcase
    end

    // One-cycle events toward the engine, all in the clk domain.
    wire        step     = tclk_rise && trst_s;
    wire        cap_ev   = step && (tap == T_CAPDR);
    wire        upd_ev   = step && (tap == T_UPDR);
    wire        csr_wr   = upd_ev && (ir == `DMAE_IDX_CSR);
    wire        addr_wr  = upd_ev && (ir == `DMAE_IDX_ADDR);
    wire        data_wr  = upd_ev && (ir == `DMAE_IDX_DATA);
    wire        data_cap = cap_ev && (ir == `DMAE_IDX_DATA);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tap      <= T_TLR;
            ir       <= `DMAE_IR_RESET;
            ir_shift <= 4'h0;
            dr_shift <= 32'h0000_0000;
            tdo      <= 1'b0;
            tdo_oe   <= 1'b0;
        end else if (!trst_s) begin
            tap    <= T_TLR;
            ir     <= `DMAE_IR_RESET;
            tdo_oe <= 1'b0;
        end else begin
            if (tclk_rise) begin
                tap <= next_tap;
                if (tap == T_CAPDR) begin
                    if (ir == `DMAE_IDX_CSR) begin
                        dr_shift <= csr;
                    end else if (ir == `DMAE_IDX_ADDR) begin
                        dr_shift <= addr_reg;
                    end else if (ir == `DMAE_IDX_DATA) begin
                        dr_shift <= data_reg;
                    end else begin
                        dr_shift <= 32'h0000_0000;
                    end
                end else if (tap == T_SHDR) begin
                    dr_shift <= {tdi_s, dr_shift[31:1]};
                end
                if (tap == T_CAPIR) begin
                    ir_shift <= 4'h1;
                end else if (tap == T_SHIR) begin
                    ir_shift <= {tdi_s, ir_shift[3:1]};
                end else if (tap == T_UPIR) begin
                    ir <= ir_shift;
                end else if (tap == T_TLR) begin
                    ir <= `DMAE_IR_RESET;
                end
            end
            // The pin changes on the falling test clock, as a tool expects.
            if (tclk_fall) begin
                tdo    <= (tap == T_SHIR) ? ir_shift[0] : dr_shift[0];
                tdo_oe <= (tap == T_SHDR) || (tap == T_SHIR);
            end
        end
    end

    // ======================================================================
    // Register file and transfer engine
    reg  [1:0]  bst;
    reg  [31:0] work_addr;
    reg  [13:0] work_left;
    reg  [13:0] read_left;
    reg         reload;
    reg         wdata_pend;
    reg         word_held;
    wire [13:0] cnt_field = csr[`DMAE_F_CNT_HI:`DMAE_F_CNT_LO];
    wire        go        = csr[`DMAE_F_GO];
    wire        dir_wr    = csr[`DMAE_F_DIR];
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire [31:0] fifo_out_data;
    wire        beat_end  = (bst == B_DATA) && hready;
    wire        beat_err  = (bst == B_DATA) && (hresp == `DMAE_HRESP_ERROR);
    wire        rd_push   = beat_end && !hwrite && !beat_err && !reload;
    wire        rd_load   = fifo_out_valid && !word_held;
    // Held-back read words stall new read beats when the buffer is full.
    wire        can_start = go && sys_ok && !reload && (work_left != 14'h0000) &&
                            (dir_wr ? wdata_pend : fifo_in_ready);

    dmae_fifo #(
        .W  (32),
        .D  (`DMAE_FIFO_DEPTH),
        .AW (`DMAE_FIFO_AW)
    ) u_rd_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .flush     (csr_wr),
        .in_valid  (rd_push),
        .in_ready  (fifo_in_ready),
        .in_data   (hrdata),
        .out_valid (fifo_out_valid),
        .out_ready (!word_held),
        .out_data  (fifo_out_data)
    );

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            csr           <= `DMAE_CSR_RESET;
            addr_reg      <= 32'h0000_0000;
            data_reg      <= 32'h0000_0000;
            bst           <= B_IDLE;
            work_addr     <= 32'h0000_0000;
            work_left     <= 14'h0000;
            read_left     <= 14'h0000;
            reload        <= 1'b0;
            wdata_pend    <= 1'b0;
            word_held     <= 1'b0;
            hbusreq       <= 1'b0;
            haddr         <= 32'h0000_0000;
            htrans        <= `DMAE_HTRANS_IDLE;
            hwrite        <= 1'b0;
            hsize         <= `DMAE_SIZE_32;
            hwdata        <= 32'h0000_0000;
            bus_prio      <= 2'h0;
            rdy_n         <= 1'b1;
            err_msg       <= 15'h0000;
            err_msg_valid <= 1'b0;
        end else begin
            err_msg_valid <= 1'b0;
            bus_prio      <= csr[`DMAE_F_PRIO_HI:`DMAE_F_PRIO_LO];
            if (addr_wr) begin
                addr_reg <= dr_shift;
            end
            // Bus cycle: request, address phase, data phase.
            case (bst)
                B_IDLE: begin
                    if (reload) begin
                        // Working copies leave the programmed values untouched.
                        work_addr <= addr_reg;
                        work_left <= (cnt_field > 14'h0001) ? cnt_field : 14'h0001;
                        read_left <= (cnt_field > 14'h0001) ? cnt_field : 14'h0001;
                        reload    <= 1'b0;
                    end else if (can_start) begin
                        hbusreq <= 1'b1;
                        bst     <= B_REQ;
                    end
                end
                B_REQ: begin
                    if (hgrant && hready) begin
                        hbusreq    <= 1'b0;
                        haddr      <= work_addr;
                        htrans     <= `DMAE_HTRANS_NONSEQ;
                        hwrite     <= dir_wr;
                        hsize      <= csr[`DMAE_F_SIZE_HI:`DMAE_F_SIZE_LO];
                        wdata_pend <= 1'b0;
                        bst        <= B_ADDR;
                    end
                end
                B_ADDR: begin
                    if (hready) begin
                        htrans <= `DMAE_HTRANS_IDLE;
                        hwdata <= data_reg;
                        bst    <= B_DATA;
                    end
                end
                default: begin
                    if (beat_err) begin
                        // No retry: the access ends at the first error.
                        bst                <= B_IDLE;
                        work_left          <= 14'h0000;
                        csr[`DMAE_F_GO]    <= 1'b0;
                        csr[`DMAE_F_ERR]   <= 1'b1;
                        err_msg_valid      <= 1'b1;
                        err_msg            <= {`DMAE_ERR_CODE, SRC_PROC, `DMAE_TCODE_ERR};
                    end else if (hready) begin
                        bst       <= B_IDLE;
                        work_addr <= work_addr + (32'h0000_0001 << hsize[1:0]);
                        work_left <= work_left - 14'h0001;
                        if (hwrite && !reload) begin
                            rdy_n <= 1'b0;
                            if (work_left == 14'h0001) begin
                                csr[`DMAE_F_DV] <= 1'b0;
                                csr[`DMAE_F_GO] <= 1'b0;
                            end
                        end
                    end
                end
            endcase
            // Read words move from the buffer into the data register one at a time.
            if (rd_load) begin
                data_reg  <= fifo_out_data;
                word_held <= 1'b1;
                rdy_n     <= 1'b0;
                read_left <= read_left - 14'h0001;
                if (read_left == 14'h0001) begin
                    csr[`DMAE_F_DV] <= 1'b1;
                    csr[`DMAE_F_GO] <= 1'b0;
                end
            end else if (data_cap) begin
                word_held <= 1'b0;
            end
            // A read's scan also passes Update-DR; it must not overwrite fetched data.
            if (data_wr && dir_wr) begin
                data_reg        <= dr_shift;
                wdata_pend      <= 1'b1;
                csr[`DMAE_F_DV] <= 1'b1;
            end
            if (cap_ev) begin
                rdy_n <= 1'b1;
            end
            if (!sys_ok) begin
                rdy_n <= 1'b1;
            end
            // A control write ends any block after the beat in flight and may
            // start the next access; it outranks the status updates above.
            if (csr_wr) begin
                csr        <= {dr_shift[31:2], dr_shift[`DMAE_F_GO] ? 1'b0 : csr[`DMAE_F_ERR], 1'b0};
                reload     <= 1'b1;
                word_held  <= 1'b0;
                wdata_pend <= 1'b0;
                if (bst == B_IDLE) begin
                    work_left <= 14'h0000;
                end
            end
        end
    end
endmodule // dmae_top

// File: bench/dmae_assertions.sv
// Port checks of the access engine.
// Assumes a bind from the bench.
`timescale 1ns/1ps
module dmae_assertions #(
    parameter [3:0] SRC_PROC = 4'h0
) (
    input wire        clk,
    input wire        rstn,
    input wire        rdy_n,
    input wire        sys_rstn,
    input wire        dbg_enable,
    input wire        hbusreq,
    input wire        hgrant,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [2:0]  hsize,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire [1:0]  hresp,
    input wire [14:0] err_msg,
    input wire        err_msg_valid
);
    // ====================
    // Data phase tracking
    reg dph;
    reg dw;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dph <= 1'b0;
            dw <= 1'b0;
        end else if (hready) begin
            dph <= (htrans == 2'h2);
            dw <= hwrite;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ====================
    // Checks
    a_sys_blocks: assert property ((!(sys_rstn && dbg_enable)) [*8] |-> rdy_n && !hbusreq)
        else $error("busy while held");
    a_err_code: assert property (err_msg_valid |-> err_msg == {5'h03, SRC_PROC, 6'h08})
        else $error("bad fault message");
    a_err_follows: assert property (hresp == 2'h1 && !hready |-> ##[0:2] err_msg_valid)
        else $error("no fault message");
    a_err_pulse: assert property (err_msg_valid |=> !err_msg_valid)
        else $error("long fault pulse");
    a_err_no_rdy: assert property (err_msg_valid |-> (!$fell(rdy_n)) [*4])
        else $error("ready after error");
    a_rdy_holds: assert property ($fell(rdy_n) && sys_rstn && dbg_enable |=> (!rdy_n) [*8])
        else $error("ready dropped early");
    a_grant_first: assert property (htrans == 2'h2 |-> hgrant)
        else $error("no grant");
    a_wdata_hold: assert property (dph && dw && !hready |=> $stable(hwdata))
        else $error("wdata moved");
    a_wr_ready: assert property (dph && dw && hready && hresp == 2'h0 |-> ##[1:3] !rdy_n)
        else $error("no write ready");
    a_addr_align: assert property (htrans == 2'h2 |-> (haddr & ((32'h1 << hsize) - 32'h1)) == 32'h0)
        else $error("misaligned");
endmodule // dmae_assertions

// File: bench/dmae_ahb_slave.sv
// Bus slave model: grant, wait states, errors on command, write log.
// Assumes one transfer at a time.
`timescale 1ns/1ps
module dmae_ahb_slave (
    input  wire        clk,
    input  wire        rstn,
    input  wire        hbusreq,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire [3:0]  stall,
    input  wire        fail_en,
    output reg         hgrant,
    output wire [31:0] hrdata,
    output wire        hready,
    output wire [1:0]  hresp
);
    // ====================
    // Data phase and log
    reg        dp;
    reg        dw;
    reg [31:0] da;
    reg [2:0]  ds;
    reg [3:0]  wc;
    reg [31:0] wr_addr [0:15];
    reg [31:0] wr_data [0:15];
    reg [2:0]  wr_size [0:15];
    integer    nt;
    integer    nw;
    // Errors take two cycles, the first stalled.
    assign hready = !dp || (fail_en ? wc == 4'h1 : wc >= stall);
    assign hresp = (dp && fail_en) ? 2'h1 : 2'h0;
    // Off the last data cycle, read lines show the inverse.
    assign hrdata = (dp && hready) ? {da[15:0], ~da[15:0]} : {~da[15:0], da[15:0]};
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hgrant <= 1'b0;
            dp <= 1'b0;
            wc <= 4'h0;
            da <= 32'h0;
            nt <= 0;
            nw <= 0;
        end else begin
            hgrant <= hbusreq;
            if (dp && hready && !fail_en) begin
                nt <= nt + 1;
                if (dw) begin
                    wr_addr[nw[3:0]] <= da;
                    wr_data[nw[3:0]] <= hwdata;
                    wr_size[nw[3:0]] <= ds;
                    nw <= nw + 1;
                end
            end
            if (hready) begin
                dp <= (htrans == 2'h2);
                da <= haddr;
                dw <= hwrite;
                ds <= hsize;
                wc <= 4'h0;
            end else begin
                wc <= wc + 4'h1;
            end
        end
    end
endmodule // dmae_ahb_slave

// File: bench/dmae_tb_top.sv
// Bench of the access engine: drives the test port, checks bus and status.
// Assumes the slave model and checker are compiled with it.
`timescale 1ns/1ps
`include "dmae_consts.vh"
module dmae_tb_top;
    localparam [3:0] IC = `DMAE_IDX_CSR, IA = `DMAE_IDX_ADDR, ID = `DMAE_IDX_DATA;
    reg         clk, rstn, tclk, tms, tdi, trst_n, sys_rstn, dbg_enable, fail_en, o;
    reg  [3:0]  stall;
    reg  [31:0] rd;
    wire        tdo, rdy_n, hbusreq, hgrant, hwrite, hready, err_msg_valid;
    wire [31:0] haddr, hwdata, hrdata;
    wire [1:0]  htrans, hresp, bus_prio;
    wire [2:0]  hsize;
    wire [14:0] err_msg;
    integer     err_total, num_checks, n_err, i, k, b;
    dmae_top dut (.clk, .rstn, .tclk, .tms, .tdi, .trst_n, .tdo, .tdo_oe(), .rdy_n, .sys_rstn, .dbg_enable,
        .hbusreq, .hgrant, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hrdata, .hready, .hresp, .bus_prio,
        .err_msg, .err_msg_valid);
    dmae_ahb_slave slv (.clk, .rstn, .hbusreq, .haddr, .htrans, .hwrite, .hsize, .hwdata, .stall, .fail_en,
        .hgrant, .hrdata, .hready, .hresp);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (err_msg_valid === 1'b1) n_err <= n_err + 1;
    // ====================
    // Helpers
    function [31:0] cf(input go, input [1:0] pr, input dir, input [2:0] sz, input [13:0] n);
        cf = {go, 3'h0, pr, dir, sz, n, 8'h00};
    endfunction
    task chk(input string nm, input [31:0] s, input [31:0] e);
        begin
            num_checks++;
            if (s !== e) begin
                err_total++;
                $display("BAD %s exp %h seen %h", nm, e, s);
            end
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", num_checks, err_total);
            if (err_total == 0 && num_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    // Link clock idles low between scans.
    task step(input t, input d, input kp, output q);
        begin
            tms = t;
            tdi = d;
            #50 q = tdo;
            if (kp) tdi = q;
            #12.5 tclk = 1'b1;
            #62.5 tclk = 1'b0;
        end
    endtask
    // A read shifts the captured bits back in.
    task scan(input [3:0] ix, input [31:0] wd, input kp);
        integer j;
        begin
            for (j = 0; j < 4; j++) step(j < 2, 1'b0, 1'b0, o);
            for (j = 0; j < 4; j++) step(j == 3, ix[j], 1'b0, o);
            for (j = 0; j < 5; j++) step(j == 0 || j == 2, 1'b0, 1'b0, o);
            for (j = 0; j < 32; j++) begin
                step(j == 31, wd[j], kp, o);
                rd[j] = o;
            end
            step(1'b1, 1'b0, 1'b0, o);
            step(1'b0, 1'b0, 1'b0, o);
        end
    endtask
    task wr(input [3:0] ix, input [31:0] v);
        scan(ix, v, 1'b0);
    endtask
    task rd_reg(input [3:0] ix);
        scan(ix, 32'h0, 1'b1);
    endtask
    task wait_for(input sel);
        begin
            k = 0;
            while ((sel ? n_err == 0 : rdy_n !== 1'b0) && k < 5000) begin
                @(negedge clk);
                k++;
            end
            if (k == 5000) begin
                err_total++;
                $display("BAD wait exp done seen timeout");
                complete_run;
            end
        end
    endtask
    // ====================
    // Main sequence
    initial begin
        {rstn, tclk, tdi, fail_en} = 4'h0;
        {tms, trst_n, sys_rstn, dbg_enable} = 4'hf;
        stall = 4'h1;
        {err_total, num_checks, n_err} = 96'h0;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        repeat (6) @(negedge clk);
        chk("rdy_n idle", rdy_n, 32'h1);
        step(1'b0, 1'b0, 1'b0, o);
        wr(IA, 32'h10);
        wr(IC, cf(1'b1, 2'h3, 1'b1, 3'h2, 14'h1));
        chk("bus_prio", bus_prio, 32'h3);
        wr(ID, 32'hcafe_0001);
        wait_for(1'b0);
        chk("wr addr", slv.wr_addr[0], 32'h10);
        chk("wr data", slv.wr_data[0], 32'hcafe_0001);
        rd_reg(IC);
        chk("csr", rd, cf(1'b0, 2'h3, 1'b1, 3'h2, 14'h1));
        chk("rdy_n cap", rdy_n, 32'h1);
        $display("single write done");
        for (i = 0; i < 3; i++) begin
            b = slv.nw;
            wr(IA, 32'h200);
            wr(IC, cf(1'b1, 2'h0, 1'b1, i[2:0], 14'h2));
            chk("bus_prio low", bus_prio, 32'h0);
            wr(ID, 32'h1111_0000);
            wait_for(1'b0);
            rd_reg(IA);
            chk("addr kept", rd, 32'h200);
            wr(ID, 32'h2222_0000);
            wait_for(1'b0);
            chk("blk addr", slv.wr_addr[b + 1], 32'h200 + (32'h1 << i));
            chk("blk size", slv.wr_size[b], i);
            chk("blk data", slv.wr_data[b + 1], 32'h2222_0000);
            rd_reg(IC);
            chk("csr blk", rd, cf(1'b0, 2'h0, 1'b1, i[2:0], 14'h2));
        end
        $display("block writes done");
        stall = 4'h2;
        b = slv.nt;
        wr(IA, 32'h84);
        wr(IC, cf(1'b1, 2'h1, 1'b0, 3'h2, 14'h0));
        wait_for(1'b0);
        rd_reg(IC);
        chk("csr rd1", rd, cf(1'b0, 2'h1, 1'b0, 3'h2, 14'h0) | 32'h1);
        rd_reg(ID);
        chk("rd1 data", rd, {16'h0084, 16'hff7b});
        chk("rd1 beats", slv.nt - b, 32'h1);
        wr(IA, 32'h40);
        wr(IC, cf(1'b1, 2'h1, 1'b0, 3'h2, 14'ha));
        for (i = 0; i < 10; i++) begin
            wait_for(1'b0);
            if (i == 0) repeat (300) @(negedge clk);
            rd_reg(ID);
            b = 32'h40 + 4 * i;
            chk("blk rd data", rd, {b[15:0], ~b[15:0]});
        end
        rd_reg(IC);
        chk("csr blk rd", rd, cf(1'b0, 2'h1, 1'b0, 3'h2, 14'ha) | 32'h1);
        $display("reads done");
        @(negedge clk);
        fail_en = 1'b1;
        wr(IA, 32'h80);
        wr(IC, cf(1'b1, 2'h0, 1'b1, 3'h2, 14'h1));
        wr(ID, 32'h9);
        wait_for(1'b1);
        @(negedge clk);
        fail_en = 1'b0;
        chk("err_msg", err_msg, {17'h0, 5'h03, 4'h0, 6'h08});
        chk("err rdy_n", rdy_n, 32'h1);
        rd_reg(IC);
        chk("csr err", rd & 32'hffff_fffe, cf(1'b0, 2'h0, 1'b1, 3'h2, 14'h1) | 32'h2);
        chk("err count", n_err, 32'h1);
        $display("bus error done");
        wr(IA, 32'h300);
        wr(IC, cf(1'b1, 2'h0, 1'b1, 3'h2, 14'h4));
        wr(ID, 32'h7);
        wait_for(1'b0);
        b = slv.nt;
        wr(IC, cf(1'b0, 2'h0, 1'b1, 3'h2, 14'h4));
        wr(ID, 32'h8);
        repeat (50) @(negedge clk);
        chk("stopped", slv.nt, b);
        $display("early stop done");
        for (i = 0; i < 2; i++) begin
            @(negedge clk);
            sys_rstn = (i != 0);
            dbg_enable = (i == 0);
            b = slv.nt;
            wr(IA, 32'h90);
            wr(IC, cf(1'b1, 2'h0, 1'b1, 3'h2, 14'h1));
            wr(ID, 32'h5);
            repeat (100) @(negedge clk);
            chk("held beats", slv.nt, b);
            chk("held rdy_n", rdy_n, 32'h1);
            wr(IC, cf(1'b0, 2'h0, 1'b1, 3'h2, 14'h1));
            @(negedge clk);
            {sys_rstn, dbg_enable} = 2'h3;
        end
        $display("system hold done");
        complete_run;
    end
endmodule // dmae_tb_top
bind dmae_top dmae_assertions #(.SRC_PROC(SRC_PROC)) u_chk (.clk, .rstn, .rdy_n, .sys_rstn, .dbg_enable,
    .hbusreq, .hgrant, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hresp, .err_msg, .err_msg_valid);
